// [pin_i2c_cfg_pkg.sv]
/*
 * Constants for the pin two/three and I2C master configuration bank:
 * register indices, field positions, reset values and watchdog timing.
 * Assumes a 10 MHz device clock; registers are 8 bits wide.
 */
package pin_i2c_cfg_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] PINS_CFG_ADDR = 8'h0E;
	localparam logic [7:0] I2C_CFG_ADDR = 8'h0F;

	// pins_two_three_config fields
	localparam int P3_OUT_BIT = 7;
	localparam int P3_REM_BIT = 6;
	localparam int P3_DIR_BIT = 5;
	localparam int P3_EN_BIT = 4;
	localparam int P2_OUT_BIT = 3;
	localparam int P2_REM_BIT = 2;
	localparam int P2_RSVD_BIT = 1;
	localparam int P2_EN_BIT = 0;
	localparam logic [7:0] PINS_CFG_RST = 8'h35;

	// i2c_master_settings fields
	localparam int SDA_DLY_LSB = 3;
	localparam int SDA_DLY_MSB = 4;
	localparam int LWD_BIT = 2;
	localparam int WD_FAST_BIT = 1;
	localparam int WD_OFF_BIT = 0;
	localparam logic [7:0] I2C_CFG_RST = 8'h00;
	localparam logic [7:0] I2C_CFG_WMASK = 8'h1F;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int WD_FAST_US = 50;
	localparam int WD_SLOW_S = 1;
	localparam int WD_FAST_CYC = WD_FAST_US * (CLK_HZ / 1_000_000);
	localparam int WD_SLOW_CYC = WD_SLOW_S * CLK_HZ;
	localparam int SDA_BASE_NS = 350;
	localparam int SDA_STEP_NS = 50;
	localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
	localparam int SDA_BASE_CYC = SDA_BASE_NS / CLK_NS;
	localparam int SDA_STEP_CYC = SDA_STEP_NS / CLK_NS;
	localparam int RECOVER_PULSES = 9;
	localparam int SCL_HALF_CYC = 50;
endpackage : pin_i2c_cfg_pkg

// [sda_delay_line.sv]
/*
 * Delays the SDA output level by a programmable cycle count.
 * Assumes delay_i is held steady while the line is in use.
 */
`timescale 1ns/1ps
`default_nettype none
module sda_delay_line #(
	parameter int DEPTH = 10
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] delay_i,
	input wire logic sda_i,
	output logic sda_o
);
	logic [DEPTH-1:0] tap_ff;
	logic [DEPTH-1:0] nxt_tap;

	// ----------------------------------------------------------------
	// shift chain, one stage per bit
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++)
		begin : g_tap
			if (g == 0)
			begin : g_first
				assign nxt_tap[g] = sda_i;
			end
			else
			begin : g_rest
				assign nxt_tap[g] = tap_ff[g-1];
			end
		end
	endgenerate

	// idle sda is high, so the chain resets to ones
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			tap_ff <= '1;
		else
			tap_ff <= nxt_tap;
	end

	// delays beyond the chain saturate at its last tap rather than reading past it
	wire [3:0] last_tap = 4'(DEPTH - 1);
	wire [3:0] sel = (delay_i == 4'h0) ? 4'h0 :
		(delay_i > last_tap) ? last_tap : delay_i - 4'h1;
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			sda_o <= 1'b1;
		else
			sda_o <= tap_ff[sel];
	end
endmodule : sda_delay_line
`default_nettype wire

// [pin_i2c_cfg.sv]
/*
 * Configuration bank for general pins two and three and the I2C master:
 * pin drive control, SDA output delay, remote write lock and a bus
 * watchdog with nine-clock recovery. Registers are reached on the
 * device's internal register port; wr_remote_i marks writes that arrive
 * over the control channel. Pin inputs are synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_i2c_cfg #(
	parameter int WD_SLOW_CYCLES = pin_i2c_cfg_pkg::WD_SLOW_CYC,
	parameter int WD_FAST_CYCLES = pin_i2c_cfg_pkg::WD_FAST_CYC
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic wr_i,
	input wire logic wr_remote_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic wr_rejected_o,
	// pass-through from the far side
	input wire logic pass_req_i,
	output logic pass_grant_o,
	// general pins
	input wire logic [1:0] remote_val_i,
	input wire logic [1:0] pin_in_i,
	output logic [1:0] pin_out_o,
	output logic [1:0] pin_oe_n_o,
	output logic [1:0] pin_val_o,
	// i2c bus
	input wire logic scl_in_i,
	input wire logic sda_in_i,
	input wire logic sda_master_i,
	output logic scl_out_o,
	output logic scl_oe_n_o,
	output logic sda_out_o,
	output logic sda_oe_n_o,
	output logic bus_free_o,
	output logic recovering_o
);
	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_s1_ff;
	logic rst_ff;
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rst_s1_ff <= 1'b0;
			rst_ff <= 1'b0;
		end
		else
		begin
			rst_s1_ff <= 1'b1;
			rst_ff <= rst_s1_ff;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] pins_cfg_ff;
	logic [7:0] i2c_cfg_ff;
	wire lock = i2c_cfg_ff[pin_i2c_cfg_pkg::LWD_BIT];
	wire blocked = wr_remote_i & lock;
	wire wr_ok = wr_i & ~blocked;
	wire wr_pins = wr_ok & (addr_i == pin_i2c_cfg_pkg::PINS_CFG_ADDR);
	wire wr_i2c = wr_ok & (addr_i == pin_i2c_cfg_pkg::I2C_CFG_ADDR);
	// pass-through traffic never consults the lock bit
	assign pass_grant_o = pass_req_i;

	always_ff @(posedge clk_i or negedge rst_ff)
	begin
		if (!rst_ff)
		begin
			pins_cfg_ff <= pin_i2c_cfg_pkg::PINS_CFG_RST;
			i2c_cfg_ff <= pin_i2c_cfg_pkg::I2C_CFG_RST;
			wr_rejected_o <= 1'b0;
		end
		else
		begin
			if (wr_pins)
				pins_cfg_ff <= wdata_i;
			if (wr_i2c)
				i2c_cfg_ff <= wdata_i & pin_i2c_cfg_pkg::I2C_CFG_WMASK;
			wr_rejected_o <= wr_i & blocked;
		end
	end

	// read mux; unmapped addresses read zero
	wire [7:0] rd_mux = (addr_i == pin_i2c_cfg_pkg::PINS_CFG_ADDR) ? pins_cfg_ff :
		(addr_i == pin_i2c_cfg_pkg::I2C_CFG_ADDR) ? i2c_cfg_ff : 8'h00;
	always_ff @(posedge clk_i or negedge rst_ff)
	begin
		if (!rst_ff)
			rdata_o <= 8'h00;
		else
			rdata_o <= rd_mux;
	end

	// ----------------------------------------------------------------
	// general pins
	// ----------------------------------------------------------------
	// pin two has no direction bit and drives whenever its enable bit is set
	wire [1:0] en = {pins_cfg_ff[pin_i2c_cfg_pkg::P3_EN_BIT],
		pins_cfg_ff[pin_i2c_cfg_pkg::P2_EN_BIT]};
	wire [1:0] rem = {pins_cfg_ff[pin_i2c_cfg_pkg::P3_REM_BIT],
		pins_cfg_ff[pin_i2c_cfg_pkg::P2_REM_BIT]};
	wire [1:0] loc = {pins_cfg_ff[pin_i2c_cfg_pkg::P3_OUT_BIT],
		pins_cfg_ff[pin_i2c_cfg_pkg::P2_OUT_BIT]};
	wire [1:0] is_in = {pins_cfg_ff[pin_i2c_cfg_pkg::P3_DIR_BIT], 1'b0};
	wire [1:0] drive = en & (rem | ~is_in);
	wire [1:0] value = (rem & remote_val_i) | (~rem & loc);

	always_ff @(posedge clk_i or negedge rst_ff)
	begin
		if (!rst_ff)
		begin
			pin_out_o <= 2'h0;
			pin_oe_n_o <= 2'h3;
			pin_val_o <= 2'h0;
		end
		else
		begin
			pin_out_o <= value;
			pin_oe_n_o <= ~drive;
			pin_val_o <= pin_in_i;
		end
	end

	// ----------------------------------------------------------------
	// sda output delay
	// ----------------------------------------------------------------
	wire [1:0] dly_code = i2c_cfg_ff[pin_i2c_cfg_pkg::SDA_DLY_MSB:pin_i2c_cfg_pkg::SDA_DLY_LSB];
	// a 100 ns clock cannot place 50 ns steps, so each delay rounds down to whole cycles
	wire [9:0] dly_ns = 10'(pin_i2c_cfg_pkg::SDA_BASE_NS)
		+ 10'(dly_code) * 10'(pin_i2c_cfg_pkg::SDA_STEP_NS);
	wire [3:0] dly_cyc = 4'(dly_ns / 10'(pin_i2c_cfg_pkg::CLK_NS));
	logic sda_dly;
	sda_delay_line #(
		.DEPTH(10)
	) u_sda_dly (
		.clk_i(clk_i),
		.rst_n_i(rst_ff),
		.delay_i(dly_cyc),
		.sda_i(sda_master_i),
		.sda_o(sda_dly)
	);

	// ----------------------------------------------------------------
	// bus watchdog and recovery
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		WD_WATCH = 3'h1,
		WD_FREE = 3'h2,
		WD_CLEAR = 3'h4
	} wd_state_t;
	wd_state_t state_ff;
	logic [31:0] cnt_ff;
	logic [7:0] half_ff;
	logic [4:0] edges_ff;
	logic scl_ff;
	logic scl_d_ff;
	logic sda_d_ff;

	wire wd_off = i2c_cfg_ff[pin_i2c_cfg_pkg::WD_OFF_BIT];
	wire [31:0] limit = i2c_cfg_ff[pin_i2c_cfg_pkg::WD_FAST_BIT] ?
		32'(WD_FAST_CYCLES) : 32'(WD_SLOW_CYCLES);
	wire activity = (scl_in_i != scl_d_ff) | (sda_in_i != sda_d_ff);
	wire expired = (cnt_ff >= limit - 32'h1);
	wire half_done = (half_ff == 8'(pin_i2c_cfg_pkg::SCL_HALF_CYC - 1));
	wire last_edge = (edges_ff == 5'(2 * pin_i2c_cfg_pkg::RECOVER_PULSES - 1));

	// cnt_ff serves the idle timer and a separate half_ff counts scl half periods
	always_ff @(posedge clk_i or negedge rst_ff)
	begin
		if (!rst_ff)
		begin
			state_ff <= WD_WATCH;
			cnt_ff <= 32'h0;
			half_ff <= 8'h0;
			edges_ff <= 5'h0;
			scl_ff <= 1'b1;
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end
		else
		begin
			scl_d_ff <= scl_in_i;
			sda_d_ff <= sda_in_i;
			case (state_ff)
				WD_WATCH:
				begin
					if (wd_off | activity)
						cnt_ff <= 32'h0;
					else if (expired)
					begin
						cnt_ff <= 32'h0;
						state_ff <= sda_in_i ? WD_FREE : WD_CLEAR;
					end
					else
						cnt_ff <= cnt_ff + 32'h1;
				end
				WD_FREE:
				begin
					if (activity | wd_off)
						state_ff <= WD_WATCH;
				end
				WD_CLEAR:
				begin
					if (half_done)
					begin
						half_ff <= 8'h0;
						scl_ff <= ~scl_ff;
						edges_ff <= edges_ff + 5'h1;
						if (last_edge)
						begin
							edges_ff <= 5'h0;
							scl_ff <= 1'b1;
							state_ff <= WD_WATCH;
						end
					end
					else
						half_ff <= half_ff + 8'h1;
				end
				default:
					state_ff <= WD_WATCH;
			endcase
		end
	end

	// scl released except low halves of recovery pulses
	assign scl_out_o = 1'b0;
	assign scl_oe_n_o = scl_ff;
	assign sda_out_o = 1'b0;
	assign sda_oe_n_o = sda_dly | (state_ff == WD_CLEAR);
	assign bus_free_o = (state_ff == WD_FREE);
	assign recovering_o = (state_ff == WD_CLEAR);
endmodule : pin_i2c_cfg
`default_nettype wire

// [pin_i2c_cfg_props.sv]
/* checker for the pin and i2c configuration bank
   assumes it is bound into pin_i2c_cfg, one clock domain */
`timescale 1ns/1ps
`default_nettype none
module pin_i2c_cfg_props (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic wr_i,
	input wire logic wr_remote_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_rejected_o,
	input wire logic pass_req_i,
	input wire logic pass_grant_o,
	input wire logic [1:0] remote_val_i,
	input wire logic [1:0] pin_out_o,
	input wire logic [1:0] pin_oe_n_o,
	input wire logic sda_in_i,
	input wire logic scl_oe_n_o,
	input wire logic bus_free_o,
	input wire logic recovering_o
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// local pin write with a quiet cycle behind it, so pins settle two edges on
	wire logic pw = wr_i && !wr_remote_i && addr_i == pin_i2c_cfg_pkg::PINS_CFG_ADDR;
	a_pin_two_local: assert property (pw && wdata_i[0] && !wdata_i[2] ##1 !wr_i
		|=> !pin_oe_n_o[0] && pin_out_o[0] == $past(wdata_i[3], 2)) else $error("pin two value");
	a_pin_remote: assert property (pw && wdata_i[0] && wdata_i[2] ##1 !wr_i
		|=> !pin_oe_n_o[0] && pin_out_o[0] == $past(remote_val_i[0])) else $error("pin two remote");
	a_pin_off_hiz: assert property (pw && !wdata_i[0] ##1 !wr_i
		|=> pin_oe_n_o[0]) else $error("pin two not off");
	a_pin_three_dir: assert property (pw && wdata_i[4] && !wdata_i[6] ##1 !wr_i
		|=> pin_oe_n_o[1] == $past(wdata_i[5], 2)) else $error("pin three direction");
	a_reject_cause: assert property (wr_rejected_o |-> $past(wr_i && wr_remote_i))
		else $error("reject without remote write");
	a_pass_grant: assert property (pass_grant_o == pass_req_i) else $error("pass grant");
	a_free_sda_high: assert property ($rose(bus_free_o) |-> $past(sda_in_i))
		else $error("free with sda low");
	a_recover_clock: assert property ($rose(recovering_o) |-> ##[0:60] !scl_oe_n_o)
		else $error("no recovery clock");
	cover property ($rose(recovering_o));
	cover property ($rose(bus_free_o));
	cover property (wr_rejected_o);
endmodule : pin_i2c_cfg_props
bind pin_i2c_cfg pin_i2c_cfg_props pin_i2c_cfg_props_inst (.*);
`default_nettype wire

// [i2c_far_side.sv]
/* far side of the i2c pins: pulled-up scl and sda, a target able to stick
   assumes open-drain enables that are low while the device pulls low */
`timescale 1ns/1ps
`default_nettype none
module i2c_far_side (
	input wire logic scl_oe_n_i,
	input wire logic sda_oe_n_i,
	input wire logic stuck_i,
	output logic scl_o,
	output logic sda_o
);
	// wired-and lines; a stuck target holding sda is what forces recovery
	assign scl_o = scl_oe_n_i;
	assign sda_o = sda_oe_n_i && !stuck_i;
endmodule : i2c_far_side
`default_nettype wire

// [tb_pin_i2c_cfg.sv]
/* self-checking bench for the pin and i2c configuration bank
   assumes the checker binds itself in and the far side model is compiled */
`timescale 1ns/1ps
`default_nettype none
module tb_pin_i2c_cfg;
	logic clk_i = 0, arst_n_i = 0, wr_i = 0, wr_remote_i = 0, pass_req_i = 0;
	logic sda_master_i = 1, stuck = 0, rej, grant, scl_in_i, sda_in_i;
	logic scl_oe_n_o, sda_oe_n_o, bus_free_o, recovering_o;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, obs, d, q[$];
	logic [1:0] remote_val_i = 2'h0, pin_out_o, pin_oe_n_o, pin_in_i = 2'h0, pin_val_o;
	logic scl_out_o, sda_out_o;
	logic [2:0] sel = 3'h0;
	int err_count = 0, checks_done = 0, cyc = 0, falls = 0, dl = 0;
	integer seed = 32'h8c13;
	pin_i2c_cfg #(.WD_SLOW_CYCLES(400), .WD_FAST_CYCLES(100)) pin_i2c_cfg_inst (.clk_i,
		.arst_n_i, .addr_i, .wr_i, .wr_remote_i, .wdata_i, .rdata_o, .wr_rejected_o(rej),
		.pass_req_i, .pass_grant_o(grant), .remote_val_i, .pin_in_i, .pin_out_o,
		.pin_oe_n_o, .pin_val_o, .scl_in_i, .sda_in_i, .sda_master_i, .scl_out_o,
		.scl_oe_n_o, .sda_out_o, .sda_oe_n_o, .bus_free_o, .recovering_o);
	i2c_far_side i2c_far_side_inst (.scl_oe_n_i(scl_oe_n_o), .sda_oe_n_i(sda_oe_n_o),
		.stuck_i(stuck), .scl_o(scl_in_i), .sda_o(sda_in_i));
	// ----------------------------------------------------------------
	// clock, watchdog of the run, observation
	// ----------------------------------------------------------------
	always #50 clk_i = ~clk_i;
	always @(negedge scl_oe_n_o) falls++;
	// pin values only matter while driven, so undriven ones are masked
	assign obs = sel == 3'h0 ? rdata_o : sel == 3'h1 ? {4'h0, pin_oe_n_o, pin_out_o & ~pin_oe_n_o}
		: sel == 3'h2 ? {6'h0, grant, rej} : sel == 3'h3 ? {6'h0, scl_oe_n_o, sda_oe_n_o}
		: sel == 3'h4 ? {7'h0, recovering_o} : sel == 3'h5 ? {7'h0, bus_free_o}
		: sel == 3'h6 ? 8'(falls) : {4'h0, pin_val_o, scl_out_o, sda_out_o};
	// oldest note against what the outputs show at this edge
	always @(posedge clk_i)
	begin
		cyc++;
		if (q.size() > 0)
			check(obs, q.pop_front());
		if (cyc == 20000)
		begin
			err_count++;
			finish_test;
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks_done++;
		if (seen !== want)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#5;
	endtask : tick
	task automatic note(input logic [2:0] s, input logic [7:0] v);
		sel = s;
		q.push_back(v);
		tick(1);
	endtask : note
	task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic r);
		addr_i = a;
		wdata_i = v;
		wr_remote_i = r;
		wr_i = 1;
		tick(1);
		wr_i = 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] v);
		addr_i = a;
		tick(1);
		note(0, v);
	endtask : rd
	// expected {oe_n, masked out}; pin two has no direction bit
	function automatic logic [7:0] pins(input logic [7:0] c, input logic [1:0] rv);
		logic d3;
		logic d2;
		d3 = c[4] && (c[6] || !c[5]);
		d2 = c[0];
		return {4'h0, !d3, !d2, d3 & (c[6] ? rv[1] : c[7]), d2 & (c[2] ? rv[0] : c[3])};
	endfunction : pins
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		tick(20);
		arst_n_i = 1;
		tick(3);
		rd(8'h0E, 8'h35);
		rd(8'h0F, 8'h00);
		rd(8'h10, 8'h00);
		note(1, pins(8'h35, 2'h0));
		repeat (16)
		begin
			d = 8'($random(seed));
			remote_val_i = 2'($random(seed));
			pin_in_i = 2'($random(seed));
			wr(8'h0E, d, 0);
			tick(1);
			note(1, pins(d, remote_val_i));
			note(7, {4'h0, pin_in_i, 2'h0});
			rd(8'h0E, d);
		end
		$display("done: pins");
		wr(8'h0F, 8'hFF, 0);
		tick(1);
		rd(8'h0F, 8'h1F);
		pass_req_i = 1;
		wr(8'h0E, 8'h00, 1);
		note(2, 8'h03);
		rd(8'h0E, d);
		wr(8'h0F, 8'h01, 0);
		tick(1);
		wr(8'h0E, 8'h11, 1);
		note(2, 8'h02);
		rd(8'h0E, 8'h11);
		$display("done: lock");
		// watchdog held off so sda edges cannot start a recovery
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h0F, 8'(k * 8 + 1), 0);
			tick(60);
			sda_master_i = 0;
			// nominal delay in whole clock periods; the line adds one register stage
			dl = (pin_i2c_cfg_pkg::SDA_BASE_NS + k * pin_i2c_cfg_pkg::SDA_STEP_NS)
				/ pin_i2c_cfg_pkg::CLK_NS;
			tick(dl);
			note(3, 8'h03);
			note(3, 8'h02);
			sda_master_i = 1;
			tick(60);
		end
		$display("done: sda delay");
		wr(8'h0F, 8'h00, 0);
		stuck = 1;
		falls = 0;
		tick(150);
		note(4, 8'h00);
		tick(300);
		note(4, 8'h01);
		tick(1050);
		note(6, 8'h09);
		stuck = 0;
		tick(500);
		note(5, 8'h01);
		wr(8'h0F, 8'h01, 0);
		stuck = 1;
		falls = 0;
		tick(600);
		note(6, 8'h00);
		wr(8'h0F, 8'h02, 0);
		tick(150);
		note(4, 8'h01);
		$display("done: watchdog");
		finish_test;
	end
endmodule : tb_pin_i2c_cfg
`default_nettype wire
